// *** fbop_pkg.sv ***
// package: pin timing, opcodes and field positions for the flash bus controller
package fbop_pkg;
	// clock rate and derived counts
	localparam int CLK_PERIOD_NS     = 25;
	localparam int STEP_TIME_NS      = 100;  // least width of each strobe phase
	localparam int STEP_CYC          = (STEP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int PROT_TIME_US      = 100;  // protect pulse width
	localparam int PROT_CYC          = (PROT_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int UNPROT_TIME_MS    = 10;   // unprotect operation time
	localparam int UNPROT_CYC        = (UNPROT_TIME_MS * 1000000 + CLK_PERIOD_NS - 1)
	                                   / CLK_PERIOD_NS;
	localparam int IDLE_TIME_NS      = 150;  // bus inactivity before auto standby
	localparam int IDLE_CYC          = (IDLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CNT_W             = 20;
	// widths
	localparam int ADDR_W            = 16;
	localparam int DATA_W            = 16;
	// operation codes on the command port
	localparam logic [2:0] OP_READ     = 3'h0;
	localparam logic [2:0] OP_WRITE    = 3'h1;
	localparam logic [2:0] OP_ID_READ  = 3'h2;
	localparam logic [2:0] OP_PROTECT  = 3'h3;
	localparam logic [2:0] OP_UNPROT   = 3'h4;
	localparam logic [2:0] OP_PVERIFY  = 3'h5;
	localparam logic [2:0] OP_UVERIFY  = 3'h6;
	// address bit positions
	localparam int A_SEL0            = 0;
	localparam int A_SEL1            = 1;
	localparam int A_VER6            = 6;
	localparam int A_SECT_LO         = 12;
	localparam int A_SECT_HI         = 15;
	localparam logic [ADDR_W-1:0] ADDR_RESET = 16'h0000;
	localparam logic [DATA_W-1:0] DATA_RESET = 16'h0000;
endpackage : fbop_pkg

// *** fbop_timer.sv ***
// file: down counter that marks the end of a programmed wait
`timescale 1ns/1ps
module fbop_timer (
	// clock and reset
	input  wire logic                       i_core_clk,
	input  wire logic                       i_rst,
	// control
	input  wire logic                       i_load,
	input  wire logic [fbop_pkg::CNT_W-1:0] i_count,
	// status
	output logic                            o_done
);
	typedef struct packed {
		logic [fbop_pkg::CNT_W-1:0] cnt; // cycles still to wait
		logic                       done;
	} fbop_tmr_t;
	fbop_tmr_t st, next_st;

	// count down to one, then flag done
	always_comb begin
		next_st = st;
		if (i_load) begin
			next_st.cnt  = i_count;
			next_st.done = 1'b0;
		end else if (st.cnt > 1) begin
			next_st.cnt = st.cnt - 1'b1;
		end else begin
			next_st.done = 1'b1; // holds until next load
		end
	end

	// state register
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			st <= '{cnt: '0, done: 1'b1};
		end else begin
			st <= next_st;
		end
	end

	assign o_done = st.done;
endmodule : fbop_timer

// *** fbop_ctrl.sv ***
// file: host side controller that drives the flash pins for bus and protection operations
`timescale 1ns/1ps
// Notes on behaviour
// - reads drive chip enable and output gate low
// - write only with enable, strobe low, gate high
// - protect raises line nine, gate; sector lines
// - protect strobe low for 100 us
// - elevated reset temporarily unprotects blocks
// - protect all blocks before unprotecting (not done here; OP_UNPROT leaves it to the caller)
// - unprotect elevates nine, gate, enable; lines high
// - verify each block individually after unprotect (not done here; OP_UVERIFY checks one sector per request, left to the caller)
module fbop_ctrl (
	// clock and reset
	input  wire logic                        i_core_clk,
	input  wire logic                        i_rst,
	// command port
	input  wire logic                        i_req,
	input  wire logic [2:0]                  i_op,
	input  wire logic [fbop_pkg::ADDR_W-1:0] i_addr,
	input  wire logic [fbop_pkg::DATA_W-1:0] i_wdata,
	input  wire logic                        i_byte_mode,
	input  wire logic                        i_temp_unprot,
	output logic                             o_busy,
	output logic                             o_rvalid,
	output logic [fbop_pkg::DATA_W-1:0]      o_rdata,
	// flash pins
	output logic                             o_chip_en_n,
	output logic                             o_out_gate_n,
	output logic                             o_write_n,
	output logic                             o_reset_unprotect_n,
	output logic                             o_word_sel,
	output logic [fbop_pkg::ADDR_W-1:0]      o_addr,
	output logic                             o_top_data_or_low_address_line,
	output logic [fbop_pkg::DATA_W-1:0]      o_dq,
	output logic                             o_dq_oe,
	input  wire logic [fbop_pkg::DATA_W-1:0] i_dq,
	input  wire logic                        i_ready_busy_n,
	// elevated identification level qualifiers
	output logic                             o_elevated_id_level_a9,
	output logic                             o_elevated_id_level_gate,
	output logic                             o_elevated_id_level_ce,
	output logic                             o_elevated_id_level_rst
);
	// one-hot phases of a bus transfer
	typedef enum logic [6:0] {
		S_IDLE  = 7'h01,
		S_SETUP = 7'h02, // address and qualifiers settle
		S_STRB  = 7'h04, // strobe low
		S_HOLD  = 7'h08, // strobe released, data hold
		S_UWAIT = 7'h10, // unprotect run time
		S_SAMP  = 7'h20, // read data capture
		S_STBY  = 7'h40  // auto standby, bus parked
	} fbop_state_t;

	typedef struct packed {
		fbop_state_t                  state;
		logic [2:0]                   op;
		logic [fbop_pkg::CNT_W-1:0]   cnt;
		logic                         busy;
		logic                         rvalid;
		logic [fbop_pkg::DATA_W-1:0]  rdata;
		logic                         ce_n;
		logic                         oe_n;
		logic                         we_n;
		logic                         word_sel;
		logic [fbop_pkg::ADDR_W-1:0]  addr;
		logic                         alow;
		logic [fbop_pkg::DATA_W-1:0]  dq;
		logic                         dq_oe;
		logic                         e_a9;
		logic                         e_gate;
		logic                         e_ce;
		logic                         e_rst;
	} fbop_st_t;

	fbop_st_t st, next_st;
	logic     tmr_load;  // start the long unprotect wait
	logic     tmr_done;  // unprotect wait has run out

	// the 10 ms wait lives in its own counter; this counter has the same CNT_W width
	fbop_timer u_unprot_tmr (
		.i_core_clk (i_core_clk),
		.i_rst      (i_rst),
		.i_load     (tmr_load),
		.i_count    (fbop_pkg::CNT_W'(fbop_pkg::UNPROT_CYC)),
		.o_done     (tmr_done)
	);

	// next-state logic for pins and sequencing
	always_comb begin
		next_st        = st;
		tmr_load       = 1'b0;
		next_st.rvalid = 1'b0;
		next_st.e_rst  = i_temp_unprot;
		case (st.state)
			S_IDLE, S_STBY: begin
				if (st.state == S_IDLE && st.cnt != '0) begin
					next_st.cnt = st.cnt - 1'b1;
				end else if (st.state == S_IDLE) begin
					next_st.state = S_STBY;
				end
				if (i_req) begin
					next_st.state    = S_SETUP;
					next_st.busy     = 1'b1;
					next_st.op       = i_op;
					next_st.cnt      = fbop_pkg::CNT_W'(fbop_pkg::STEP_CYC);
					next_st.word_sel = ~i_byte_mode;
					next_st.addr     = i_addr;
					// pin value kept in a flop: low address in byte mode, data msb in word mode
					next_st.alow     = i_byte_mode ? i_wdata[0]
					                 : (i_op == fbop_pkg::OP_WRITE) ? i_wdata[15] : st.dq[15];
					next_st.ce_n     = 1'b0;
					next_st.oe_n     = 1'b1;
					next_st.we_n     = 1'b1;
					next_st.dq_oe    = 1'b0;
					next_st.e_a9     = 1'b0;
					next_st.e_gate   = 1'b0;
					next_st.e_ce     = 1'b0;
					case (i_op)
						fbop_pkg::OP_WRITE: begin
							next_st.dq    = i_wdata;
							next_st.dq_oe = 1'b1;
						end
						fbop_pkg::OP_ID_READ: begin
							next_st.e_a9 = 1'b1;
							next_st.addr[fbop_pkg::A_SEL1] = 1'b0;
						end
						fbop_pkg::OP_PROTECT: begin
							next_st.e_a9   = 1'b1;
							next_st.e_gate = 1'b1;
						end
						fbop_pkg::OP_UNPROT: begin
							next_st.e_a9   = 1'b1;
							next_st.e_gate = 1'b1;
							// caller must lock every sector first; this block cannot see the locks
							next_st.e_ce   = 1'b1;
							next_st.addr[fbop_pkg::A_SECT_LO] = 1'b1;
							next_st.addr[fbop_pkg::A_SECT_HI] = 1'b1;
						end
						fbop_pkg::OP_PVERIFY, fbop_pkg::OP_UVERIFY: begin
							next_st.e_a9 = 1'b1;
							next_st.addr[fbop_pkg::A_SEL0] = 1'b0;
							next_st.addr[fbop_pkg::A_SEL1] = 1'b1;
							next_st.addr[fbop_pkg::A_VER6] = (i_op == fbop_pkg::OP_UVERIFY);
						end
						default: begin
						end
					endcase
				end
			end
			S_SETUP: begin
				if (st.cnt > 1) begin
					next_st.cnt = st.cnt - 1'b1;
				end else begin
					next_st.cnt = fbop_pkg::CNT_W'(fbop_pkg::STEP_CYC);
					case (st.op)
						fbop_pkg::OP_WRITE: begin
							next_st.we_n  = 1'b0;
							next_st.state = S_STRB;
						end
						fbop_pkg::OP_PROTECT: begin
							next_st.we_n  = 1'b0;
							next_st.cnt   = fbop_pkg::CNT_W'(fbop_pkg::PROT_CYC);
							next_st.state = S_STRB;
						end
						fbop_pkg::OP_UNPROT: begin
							next_st.we_n  = 1'b0;
							tmr_load      = 1'b1;
							next_st.state = S_UWAIT;
						end
						default: begin
							next_st.oe_n  = 1'b0;
							next_st.state = S_STRB;
						end
					endcase
				end
			end
			S_STRB: begin
				if (st.cnt > 1) begin
					next_st.cnt = st.cnt - 1'b1;
				end else if (st.op == fbop_pkg::OP_WRITE || st.op == fbop_pkg::OP_PROTECT) begin
					next_st.we_n  = 1'b1;
					next_st.cnt   = fbop_pkg::CNT_W'(fbop_pkg::STEP_CYC);
					next_st.state = S_HOLD;
				end else begin
					next_st.state = S_SAMP;
				end
			end
			S_UWAIT: begin
				if (tmr_done && !tmr_load) begin
					next_st.we_n  = 1'b1;
					next_st.cnt   = fbop_pkg::CNT_W'(fbop_pkg::STEP_CYC);
					next_st.state = S_HOLD;
				end
			end
			S_SAMP: begin
				next_st.rvalid = 1'b1;
				next_st.rdata  = i_dq;
				if (st.op == fbop_pkg::OP_ID_READ && !st.word_sel) begin
					next_st.rdata[15:8] = 8'h00;
				end
				next_st.oe_n  = 1'b1;
				next_st.cnt   = fbop_pkg::CNT_W'(fbop_pkg::STEP_CYC);
				next_st.state = S_HOLD;
			end
			S_HOLD: begin
				if (st.cnt > 1) begin
					next_st.cnt = st.cnt - 1'b1;
				end else begin
					next_st.ce_n   = 1'b1;
					next_st.dq_oe  = 1'b0;
					next_st.e_a9   = 1'b0;
					next_st.e_gate = 1'b0;
					next_st.e_ce   = 1'b0;
					next_st.busy   = 1'b0;
					next_st.cnt    = fbop_pkg::CNT_W'(fbop_pkg::IDLE_CYC);
					next_st.state  = S_IDLE;
				end
			end
			default: begin
				next_st.state = S_IDLE;
			end
		endcase
	end

	// state register; strobes idle high, elevated levels off
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			st          <= '0;
			st.state    <= S_IDLE;
			st.op       <= fbop_pkg::OP_READ;
			st.ce_n     <= 1'b1;
			st.oe_n     <= 1'b1;
			st.we_n     <= 1'b1;
			st.word_sel <= 1'b1;
			st.addr     <= fbop_pkg::ADDR_RESET;
			st.dq       <= fbop_pkg::DATA_RESET;
		end else begin
			st <= next_st;
		end
	end

	// outputs straight from state flops, except the reset pin tied high
	assign o_busy                         = st.busy;
	assign o_rvalid                       = st.rvalid;
	assign o_rdata                        = st.rdata;
	assign o_chip_en_n                    = st.ce_n;
	assign o_out_gate_n                   = st.oe_n;
	assign o_write_n                      = st.we_n;
	assign o_reset_unprotect_n            = 1'b1; // reset pin parked high; elevation via qualifier
	assign o_word_sel                     = st.word_sel;
	assign o_addr                         = st.addr;
	assign o_top_data_or_low_address_line = st.alow;
	assign o_dq                           = st.dq;
	assign o_dq_oe                        = st.dq_oe;
	assign o_elevated_id_level_a9         = st.e_a9;
	assign o_elevated_id_level_gate       = st.e_gate;
	assign o_elevated_id_level_ce         = st.e_ce;
	assign o_elevated_id_level_rst        = st.e_rst;
endmodule : fbop_ctrl

// *** fbop_ctrl_chk.sv ***
// checker: pin timing assertions for the flash bus controller
`timescale 1ns/1ps
module fbop_ctrl_chk (
	// clock and reset
	input wire logic        i_core_clk,
	input wire logic        i_rst,
	// watched ports
	input wire logic        i_temp_unprot,
	input wire logic        o_busy,
	input wire logic        o_rvalid,
	input wire logic        o_chip_en_n,
	input wire logic        o_out_gate_n,
	input wire logic        o_write_n,
	input wire logic [15:0] o_addr,
	input wire logic [15:0] o_dq,
	input wire logic        o_dq_oe,
	input wire logic        o_elevated_id_level_gate,
	input wire logic        o_elevated_id_level_ce,
	input wire logic        o_elevated_id_level_rst
);
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (i_rst);
	logic [19:0] lo_cnt; // cycles the strobe has stayed low
	// counter rather than a long repetition, so the protect pulse stays cheap to check
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) lo_cnt <= 20'h00000;
		else lo_cnt <= o_write_n ? 20'h00000 : lo_cnt + 20'h00001;
	end
	a_read_ce: assert property (!o_out_gate_n |-> !o_chip_en_n)
		else $error("gate low without chip enable");
	a_read_lat: assert property ($fell(o_out_gate_n) |-> ##5 o_rvalid ##1 !o_rvalid)
		else $error("read data pulse misplaced");
	a_write_qual: assert property (!o_write_n && !o_elevated_id_level_gate
		|-> o_out_gate_n && !o_chip_en_n)
		else $error("write strobe without enable or with gate low");
	a_addr_hold: assert property (!o_write_n |-> $stable(o_addr))
		else $error("address moved under write strobe");
	a_data_hold: assert property (!o_write_n && !o_elevated_id_level_gate
		|-> o_dq_oe && $stable(o_dq))
		else $error("write data not held");
	a_data_edge: assert property ($rose(o_write_n) && !$past(o_elevated_id_level_gate)
		|-> o_dq_oe && lo_cnt == fbop_pkg::STEP_CYC)
		else $error("write strobe width or data release wrong");
	a_no_fight: assert property (!o_out_gate_n |-> !o_dq_oe)
		else $error("host drives data during read");
	a_standby: assert property (o_chip_en_n && !o_busy |-> !o_dq_oe && o_out_gate_n && o_write_n)
		else $error("idle pins not parked");
	a_prot_width: assert property ($rose(o_write_n) && $past(o_elevated_id_level_gate)
		&& !$past(o_elevated_id_level_ce) |-> lo_cnt >= fbop_pkg::PROT_CYC)
		else $error("protect pulse too short");
	a_temp_follow: assert property ($changed(i_temp_unprot)
		|=> o_elevated_id_level_rst == $past(i_temp_unprot))
		else $error("temporary unprotect level not passed on");
	c_read: cover property (o_rvalid);
	c_protect: cover property ($rose(o_write_n) && $past(o_elevated_id_level_gate));
	c_temp: cover property ($rose(o_elevated_id_level_rst));
	c_unprot: cover property ($fell(o_write_n) && o_elevated_id_level_ce);
endmodule : fbop_ctrl_chk
bind fbop_ctrl fbop_ctrl_chk i_fbop_ctrl_chk (.i_core_clk, .i_rst, .i_temp_unprot, .o_busy, .o_rvalid,
	.o_chip_en_n, .o_out_gate_n, .o_write_n, .o_addr, .o_dq, .o_dq_oe, .o_elevated_id_level_gate,
	.o_elevated_id_level_ce, .o_elevated_id_level_rst);

// *** fbop_flash_model.sv ***
// partner: behavioural flash device seen through its pins
`timescale 1ns/1ps
module fbop_flash_model #(
	parameter logic [7:0] MAN_CODE = 8'h3c, // arbitrary maker code
	parameter logic [7:0] DEV_CODE = 8'h7e  // arbitrary part code
) (
	// clock, only for the undriven bus pattern
	input  wire logic        i_core_clk,
	// strobes and width select
	input  wire logic        i_chip_en_n,
	input  wire logic        i_out_gate_n,
	input  wire logic        i_write_n,
	input  wire logic        i_reset_unprotect_n,
	input  wire logic        i_word_sel,
	// address and data
	input  wire logic [15:0] i_addr,
	input  wire logic        i_low_addr,
	input  wire logic [15:0] i_dq,
	input  wire logic        i_dq_oe,
	output logic      [15:0] o_dq,
	output logic             o_ready_busy_n,
	// elevated level qualifiers
	input  wire logic        i_hv_id,
	input  wire logic        i_hv_gate,
	input  wire logic        i_hv_ce,
	input  wire logic        i_hv_rst
);
	logic [15:0] mem [0:255];     // store indexed by sector and low nibble
	logic [15:0] prot;            // one lock bit per sector code
	logic [15:0] wa;              // latched write address
	logic [15:0] flt = 16'h5a5a;  // changing value while undriven
	realtime     t_fall;          // strobe fall time for the protect width
	wire wr = !i_chip_en_n && !i_write_n && i_out_gate_n && !i_hv_gate;
	wire rd_en = !i_chip_en_n && !i_out_gate_n && i_reset_unprotect_n;
	wire [15:0] id = i_addr[1] ? {15'h0000, prot[i_addr[15:12]]}
		: {8'h00, i_addr[0] ? DEV_CODE : MAN_CODE};
	wire [15:0] v = i_hv_id ? id : mem[{i_addr[15:12], i_addr[3:0]}];
	// blank store, nothing locked
	initial begin
		prot = 16'h0000;
		for (int k = 0; k < 256; k++) mem[k] = 16'h0000;
	end
	// address taken when the later of enable and strobe falls
	always @(posedge wr) wa = i_addr;
	// data taken at the earlier rise; locked sectors drop it unless reset is elevated
	always @(negedge wr) begin
		if (i_dq_oe && (!prot[wa[15:12]] || i_hv_rst)) mem[{wa[15:12], wa[3:0]}] = i_dq;
	end
	always @(negedge i_write_n) t_fall = $realtime;
	// a short protect pulse is ignored; unprotect clears all sectors at once
	always @(posedge i_write_n) begin
		if (i_hv_id && i_hv_gate && i_hv_ce && i_addr[12] && i_addr[15]) begin
			// a strobe cut short before the run time leaves every lock in place
			if ($realtime - t_fall >= 10000000.0) prot = 16'h0000;
		end else if (i_hv_id && i_hv_gate && $realtime - t_fall >= 100000.0) begin
			prot[i_addr[15:12]] = 1'b1;
		end
	end
	always @(posedge i_core_clk) flt <= ~flt;
	// byte mode floats the upper lines and picks a byte by the low address line
	assign o_dq = !rd_en ? flt : i_word_sel ? v : {flt[15:8], i_low_addr ? v[15:8] : v[7:0]};
	assign o_ready_busy_n = 1'b1;
endmodule : fbop_flash_model

// *** fbop_ctrl_test.sv ***
// testbench: controller against the flash model
`timescale 1ns/1ps
`define CHK(n, e, s) begin tests_run++; if ((e) !== (s)) begin fails++; \
	$display("[ERR] %s exp %h got %h", n, e, s); end end
module fbop_ctrl_test;
	localparam logic [7:0] MAN = 8'h3c; // arbitrary maker code
	localparam logic [7:0] DEV = 8'h7e; // arbitrary part code
	logic        clk = 1'b0, rst = 1'b1, req = 1'b0, bm = 1'b0, tu = 1'b0;
	logic [2:0]  op = 3'h0;
	logic [15:0] addr = 16'h0000, wd = 16'h0000, rdat, fdq, pdq, pa;
	logic        busy, rv, ce_n, oe_n, we_n, rsu_n, ws, la, poe, hv_id, hv_g, hv_e, hv_r, rdy_n;
	int          fails = 0, tests_run = 0, cyc = 0;
	fbop_ctrl i_fbop_ctrl (.i_core_clk(clk), .i_rst(rst), .i_req(req), .i_op(op), .i_addr(addr),
		.i_wdata(wd), .i_byte_mode(bm), .i_temp_unprot(tu), .o_busy(busy), .o_rvalid(rv),
		.o_rdata(rdat), .o_chip_en_n(ce_n), .o_out_gate_n(oe_n), .o_write_n(we_n),
		.o_reset_unprotect_n(rsu_n), .o_word_sel(ws), .o_addr(pa), .o_top_data_or_low_address_line(la),
		.o_dq(pdq), .o_dq_oe(poe), .i_dq(fdq), .i_ready_busy_n(rdy_n), .o_elevated_id_level_a9(hv_id),
		.o_elevated_id_level_gate(hv_g), .o_elevated_id_level_ce(hv_e), .o_elevated_id_level_rst(hv_r));
	fbop_flash_model #(.MAN_CODE(MAN), .DEV_CODE(DEV)) i_fbop_flash_model (.i_core_clk(clk),
		.i_chip_en_n(ce_n), .i_out_gate_n(oe_n), .i_write_n(we_n), .i_reset_unprotect_n(rsu_n),
		.i_word_sel(ws), .i_addr(pa), .i_low_addr(la), .i_dq(pdq), .i_dq_oe(poe), .o_dq(fdq),
		.o_ready_busy_n(rdy_n), .i_hv_id(hv_id), .i_hv_gate(hv_g), .i_hv_ce(hv_e), .i_hv_rst(hv_r));
	always #12.5 clk = ~clk;
	// hang guard, well above the protect pulse plus the short operations
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			fails++;
			summarize();
		end
	end
	task summarize;
		if (fails == 0 && tests_run > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : summarize
	// one request, then wait for busy to drop, keeping any read data
	task automatic run(input logic [2:0] c, input logic [15:0] a, d, output logic [15:0] r);
		int n;
		n = 0;
		@(posedge clk);
		req <= 1'b1; op <= c; addr <= a; wd <= d;
		@(posedge clk);
		req <= 1'b0;
		#1;
		while (busy !== 1'b0 && n < 5000) begin
			if (rv === 1'b1) r = rdat;
			@(posedge clk);
			#1;
			n++;
		end
		`CHK("busy", 1'b0, busy)
	endtask : run
	// back to back writes, then read both back
	task t_wr_rd;
		logic [15:0] r;
		run(fbop_pkg::OP_WRITE, 16'h1234, 16'hbeef, r);
		run(fbop_pkg::OP_WRITE, 16'h1235, 16'h0f0f, r);
		run(fbop_pkg::OP_READ, 16'h1234, 16'h0000, r);
		`CHK("rd1234", 16'hbeef, r)
		run(fbop_pkg::OP_READ, 16'h1235, 16'h0000, r);
		`CHK("rd1235", 16'h0f0f, r)
	endtask : t_wr_rd
	// identifier codes with stray address bits, then byte width
	task t_id;
		logic [15:0] r;
		run(fbop_pkg::OP_ID_READ, 16'h7ff0, 16'h0000, r);
		`CHK("maker", {8'h00, MAN}, r)
		run(fbop_pkg::OP_ID_READ, 16'h0a5d, 16'h0000, r);
		`CHK("part", {8'h00, DEV}, r)
		@(posedge clk);
		bm <= 1'b1;
		run(fbop_pkg::OP_ID_READ, 16'h0001, 16'h0000, r);
		`CHK("part_byte", {8'h00, DEV}, r)
		run(fbop_pkg::OP_READ, 16'h1234, 16'h0001, r);
		`CHK("high_byte", 8'hbe, r[7:0])
		@(posedge clk);
		bm <= 1'b0;
	endtask : t_id
	// lock a sector, verify, then temporary unlock and relock
	task t_prot;
		logic [15:0] r;
		run(fbop_pkg::OP_PROTECT, 16'h3000, 16'h0000, r);
		run(fbop_pkg::OP_PVERIFY, 16'h3000, 16'h0000, r);
		`CHK("locked", 16'h0001, r)
		run(fbop_pkg::OP_UVERIFY, 16'h5000, 16'h0000, r);
		`CHK("open", 16'h0000, r)
		run(fbop_pkg::OP_WRITE, 16'h3010, 16'h1111, r);
		run(fbop_pkg::OP_READ, 16'h3010, 16'h0000, r);
		`CHK("ignored", 16'h0000, r)
		@(posedge clk);
		tu <= 1'b1;
		run(fbop_pkg::OP_WRITE, 16'h3010, 16'h2222, r);
		run(fbop_pkg::OP_READ, 16'h3010, 16'h0000, r);
		`CHK("temp_open", 16'h2222, r)
		@(posedge clk);
		tu <= 1'b0;
		run(fbop_pkg::OP_WRITE, 16'h3010, 16'h3333, r);
		run(fbop_pkg::OP_READ, 16'h3010, 16'h0000, r);
		`CHK("relocked", 16'h2222, r)
	endtask : t_prot
	// start a global unlock, cut it short by a mid-run reset, then verify the lock held
	task t_unprot;
		logic [15:0] r;
		@(posedge clk);
		req <= 1'b1; op <= fbop_pkg::OP_UNPROT; addr <= 16'h0000; wd <= 16'h0000;
		@(posedge clk);
		req <= 1'b0;
		// strobe has been low since the fourth cycle after the take
		repeat (8) @(posedge clk);
		#1;
		`CHK("unp_strobe", 1'b0, we_n)
		`CHK("unp_levels", 3'h7, ({hv_id, hv_g, hv_e}))
		`CHK("unp_lines", 2'h3, ({pa[15], pa[12]}))
		@(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		#1;
		`CHK("rst_park", 4'h3, ({busy, hv_e, we_n, ce_n}))
		run(fbop_pkg::OP_PVERIFY, 16'h3000, 16'h0000, r);
		`CHK("cut_unlock", 16'h0001, r)
		run(fbop_pkg::OP_UVERIFY, 16'h3000, 16'h0000, r);
		`CHK("sect_verify", 16'h0001, r)
	endtask : t_unprot
	// reset for two cycles, then the scenarios in turn
	initial begin
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		t_wr_rd();
		t_id();
		t_prot();
		t_unprot();
		summarize();
	end
endmodule : fbop_ctrl_test
